// [src/hbr_pkg.sv]
// Shared constants and types for the host bus read port.
package hbr_pkg;

	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned BURST_MAX = 8;
	localparam logic [3:0] BURST_LAST = 4'h7;
	localparam logic [3:0] BEATS_ZERO = 4'h0;
	localparam logic [3:0] BEATS_ONE = 4'h1;

	// Word offsets on the address lines A[9:2].
	localparam logic [ADDR_W-1:0] RXD_LAST_OFS = 8'h07;
	localparam logic [ADDR_W-1:0] RXS_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] TXS_OFS = 8'h12;
	localparam logic [ADDR_W-1:0] TEST_OFS = 8'h19;

	// Arbitrary pattern returned by the byte-order test register.
	localparam logic [DATA_W-1:0] TEST_VALUE = 32'h1a2b3c4d;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

	// Host spacing figures; the host keeps them, the counts are for reference.
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned RAW_WAIT_NS = 45;
	localparam int unsigned RAR_FIFO_INFO_NS = 135;
	localparam int unsigned RAR_DROP_NS = 180;
	localparam int unsigned RAW_WAIT_CYC = (RAW_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned RAR_FIFO_INFO_CYC = (RAR_FIFO_INFO_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned RAR_DROP_CYC = (RAR_DROP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_HOLD = 2'b11,
		ST_END  = 2'b10
	} hbr_state_e;

	typedef enum logic [2:0] {
		SRC_RXD  = 3'h0,
		SRC_RXS  = 3'h1,
		SRC_TXS  = 3'h2,
		SRC_TEST = 3'h3,
		SRC_CSR  = 3'h4
	} hbr_src_e;

	typedef struct packed {
		logic              chip_select_n;
		logic              read_strobe_n;
		logic              end_sel;
		logic [ADDR_W-1:0] addr;
	} hbr_bus_s;

	typedef struct packed {
		logic              rd;
		logic [ADDR_W-1:0] addr;
	} hbr_csr_s;

endpackage

// [src/hbr_fifo.sv]
// Show-ahead FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module hbr_fifo #(
	parameter int unsigned W = 32,
	parameter int unsigned D = 16
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_valid,
	input  wire logic [W-1:0] i_data,
	output logic              o_ready,
	output logic              o_valid,
	output logic [W-1:0]      o_data,
	input  wire logic         i_ready
);
	localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
	localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
	localparam logic [AW-1:0] LAST_PTR = AW'(D - 1);

	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic          push;
	logic          pop;

	assign o_ready = (cnt_q != FULL_CNT);
	assign o_valid = (cnt_q != '0);
	assign o_data = mem_q[rd_q];
	assign push = i_valid && o_ready;
	assign pop = i_ready && o_valid;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_q <= '0;
		end else if (push && !pop) begin
			cnt_q <= cnt_q + CNT_ONE;
		end else if (pop && !push) begin
			cnt_q <= cnt_q - CNT_ONE;
		end
	end
endmodule // hbr_fifo
`default_nettype wire

// [src/hbr_read_port.sv]
// Host bus read port: single reads of registers and FIFOs, burst reads of the data FIFO.
// Notes on behaviour
// - Test register reads have no side effects.
// - Single reads reach registers and all FIFOs.
// - Cycle runs while select and strobe both low.
// - Bursts reach up to eight dwords.
// - Burst spans one select-and-strobe assertion.
// - Address bit 2 toggle presents fresh word in data FIFO bursts.
`timescale 1ns/1ps
`default_nettype none
module hbr_read_port
	import hbr_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire hbr_bus_s          i_bus,
	output logic [DATA_W-1:0]      o_data,
	output logic                   o_data_oe,
	input  wire logic              i_rxd_valid,
	input  wire logic [DATA_W-1:0] i_rxd_data,
	output logic                   o_rxd_ready,
	input  wire logic              i_rxs_valid,
	input  wire logic [DATA_W-1:0] i_rxs_data,
	output logic                   o_rxs_pop,
	input  wire logic              i_txs_valid,
	input  wire logic [DATA_W-1:0] i_txs_data,
	output logic                   o_txs_pop,
	output hbr_csr_s               o_csr,
	input  wire logic [DATA_W-1:0] i_csr_rdata
);
	function automatic logic [DATA_W-1:0] order_bytes(input logic [DATA_W-1:0] w, input logic big);
		order_bytes = big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
	endfunction

	function automatic hbr_src_e decode(input logic [ADDR_W-1:0] a);
		if (a <= RXD_LAST_OFS) begin
			decode = SRC_RXD;
		end else if (a == RXS_OFS) begin
			decode = SRC_RXS;
		end else if (a == TXS_OFS) begin
			decode = SRC_TXS;
		end else if (a == TEST_OFS) begin
			decode = SRC_TEST;
		end else begin
			decode = SRC_CSR;
		end
	endfunction

	hbr_state_e        st_q;
	hbr_src_e          src_q;
	logic [ADDR_W-1:0] addr_q;
	logic              big_q;
	logic              a2_q;
	logic [3:0]        beats_q;
	logic              vld_q;
	logic [DATA_W-1:0] data_q;
	logic              csr_rd_q;
	logic              active;
	logic              toggle;
	logic              step;
	logic              pop_end;
	logic              rxd_pop;
	logic              head_valid;
	logic [DATA_W-1:0] head_data;
	logic              q_valid;
	logic [DATA_W-1:0] q_data;

	// A cycle or burst exists only while both strobes are low.
	assign active = !i_bus.chip_select_n && !i_bus.read_strobe_n;
	assign toggle = (i_bus.addr[0] != a2_q);
	// Toggles beyond the eighth word or outside the data FIFO are ignored.
	assign step = (st_q == ST_HOLD) && active && toggle && (src_q == SRC_RXD) && (beats_q < BURST_LAST);
	assign pop_end = (st_q == ST_END) && vld_q;
	// The presented word is consumed on a step or at the end of the cycle.
	assign rxd_pop = (src_q == SRC_RXD) && vld_q && (step || (st_q == ST_END));
	assign o_rxs_pop = pop_end && (src_q == SRC_RXS);
	assign o_txs_pop = pop_end && (src_q == SRC_TXS);
	assign o_data_oe = active && (st_q != ST_IDLE);
	assign o_data = data_q;
	assign o_csr = '{rd: csr_rd_q, addr: addr_q};

	hbr_fifo #(
		.W (DATA_W),
		.D (FIFO_DEPTH)
	) u_rxd_fifo (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_valid (i_rxd_valid),
		.i_data  (i_rxd_data),
		.o_ready (o_rxd_ready),
		.o_valid (q_valid),
		.o_data  (q_data),
		.i_ready (rxd_pop)
	);

	always_comb begin
		head_valid = 1'b1;
		head_data = ZERO_WORD;
		case (src_q)
			SRC_RXD: begin
				head_valid = q_valid;
				head_data = q_valid ? q_data : ZERO_WORD;
			end
			SRC_RXS: begin
				head_valid = i_rxs_valid;
				head_data = i_rxs_valid ? i_rxs_data : ZERO_WORD;
			end
			SRC_TXS: begin
				head_valid = i_txs_valid;
				head_data = i_txs_valid ? i_txs_data : ZERO_WORD;
			end
			SRC_TEST: begin
				// Reading the test pattern touches nothing else.
				head_valid = 1'b0;
				head_data = TEST_VALUE;
			end
			SRC_CSR: begin
				head_valid = 1'b0;
				head_data = i_csr_rdata;
			end
			default: begin
				head_valid = 1'b0;
				head_data = ZERO_WORD;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_q <= ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (active) begin
						st_q <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					st_q <= ST_HOLD;
				end
				ST_HOLD: begin
					if (!active) begin
						st_q <= ST_END;
					end else if (step) begin
						st_q <= ST_LOAD;
					end
				end
				ST_END: begin
					st_q <= ST_IDLE;
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Address and byte order are caught once, at the start of the cycle.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			src_q <= SRC_CSR;
			addr_q <= '0;
			big_q <= 1'b0;
		end else if (st_q == ST_IDLE && active) begin
			src_q <= decode(i_bus.addr);
			addr_q <= i_bus.addr;
			big_q <= i_bus.end_sel;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			a2_q <= 1'b0;
		end else if (st_q == ST_IDLE || st_q == ST_LOAD) begin
			a2_q <= i_bus.addr[0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			beats_q <= BEATS_ZERO;
		end else if (st_q == ST_IDLE) begin
			beats_q <= BEATS_ZERO;
		end else if (step) begin
			beats_q <= beats_q + BEATS_ONE;
		end
	end

	// Data is loaded one cycle after the source is known, so the FIFO head has settled.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			data_q <= ZERO_WORD;
			vld_q <= 1'b0;
		end else if (st_q == ST_LOAD) begin
			data_q <= order_bytes(head_data, big_q);
			vld_q <= head_valid;
		end else if (st_q == ST_IDLE) begin
			vld_q <= 1'b0;
		end
	end

	// The register side sees one read pulse per completed register read cycle, for its read side effects.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			csr_rd_q <= 1'b0;
		end else begin
			csr_rd_q <= (st_q == ST_HOLD) && !active && (src_q == SRC_CSR);
		end
	end

	sequence s_load_then_hold;
		st_q == ST_LOAD ##1 st_q == ST_HOLD;
	endsequence

	sequence s_close;
		st_q == ST_END ##1 st_q == ST_IDLE;
	endsequence

	property p_start;
		@(posedge i_clk) disable iff (i_rst)
		(st_q == ST_IDLE && active) |=> s_load_then_hold;
	endproperty
	a_start: assert property (p_start) else $error("cycle did not start on strobes");

	property p_oe_off;
		@(posedge i_clk) disable iff (i_rst)
		!active |-> !o_data_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("data driven with strobes high");

	property p_close;
		@(posedge i_clk) disable iff (i_rst)
		(st_q == ST_HOLD && !active) |=> s_close;
	endproperty
	a_close: assert property (p_close) else $error("cycle did not end after strobe release");

	property p_fresh;
		@(posedge i_clk) disable iff (i_rst)
		step |=> s_load_then_hold;
	endproperty
	a_fresh: assert property (p_fresh) else $error("no fresh word after address toggle");

	property p_burst_cap;
		@(posedge i_clk) disable iff (i_rst)
		beats_q <= BURST_LAST;
	endproperty
	a_burst_cap: assert property (p_burst_cap) else $error("burst passed eight words");

	property p_no_burst_other;
		@(posedge i_clk) disable iff (i_rst)
		(st_q == ST_HOLD && src_q != SRC_RXD) |=> (st_q != ST_LOAD);
	endproperty
	a_no_burst_other: assert property (p_no_burst_other) else $error("burst from non-FIFO source");

	property p_test_quiet;
		@(posedge i_clk) disable iff (i_rst)
		(src_q == SRC_TEST && st_q != ST_IDLE) |-> !(rxd_pop || o_rxs_pop || o_txs_pop || o_csr.rd);
	endproperty
	a_test_quiet: assert property (p_test_quiet) else $error("test register read had side effect");

	property p_pop_end;
		@(posedge i_clk) disable iff (i_rst)
		(st_q == ST_HOLD && !active && vld_q && src_q == SRC_RXS) |=> o_rxs_pop ##1 !o_rxs_pop;
	endproperty
	a_pop_end: assert property (p_pop_end) else $error("status FIFO not popped once");

	property p_csr_pulse;
		@(posedge i_clk) disable iff (i_rst)
		(st_q == ST_HOLD && !active && src_q == SRC_CSR) |=> o_csr.rd ##1 !o_csr.rd;
	endproperty
	a_csr_pulse: assert property (p_csr_pulse) else $error("register read pulse missing");

	property p_data_hold;
		@(posedge i_clk) disable iff (i_rst)
		(st_q == ST_HOLD && $past(st_q) == ST_HOLD) |-> $stable(o_data);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data changed without toggle");
endmodule // hbr_read_port
`default_nettype wire

// [testbench/hbr_far_model.sv]
// Far side of the read port: receive data source, two status queues and register contents.
`timescale 1ns/1ps
`default_nettype none
module hbr_far_model
	import hbr_pkg::*;
(
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_fill_en,
	input  wire logic               i_rxd_ready,
	input  wire logic               i_rxs_pop,
	input  wire logic               i_txs_pop,
	input  wire hbr_csr_s           i_csr,
	output logic                    o_rxd_valid,
	output logic [DATA_W-1:0]       o_rxd_data,
	output logic                    o_rxs_valid,
	output logic [DATA_W-1:0]       o_rxs_data,
	output logic                    o_txs_valid,
	output logic [DATA_W-1:0]       o_txs_data,
	output logic [DATA_W-1:0]       o_csr_rdata
);
	logic [4:0] fill_q;
	logic [1:0] rxs_q;
	logic [1:0] txs_q;

	// Exactly sixteen words are offered, so the buffer fills once and can then be drained dry.
	assign o_rxd_valid = i_fill_en && (fill_q < 5'h10);
	assign o_rxd_data  = 32'hd000_0000 | {27'h0, fill_q};
	// Each status queue holds two entries; the third read finds it empty.
	assign o_rxs_valid = (rxs_q < 2'h2);
	// An empty queue shows a junk pattern, so the port must mask it rather than pass it through.
	assign o_rxs_data  = o_rxs_valid ? (32'h5a00_0000 | {30'h0, rxs_q}) : ~(32'h5a00_0000 | {30'h0, rxs_q});
	assign o_txs_valid = (txs_q < 2'h2);
	assign o_txs_data  = o_txs_valid ? (32'h3c00_0000 | {30'h0, txs_q}) : ~(32'h3c00_0000 | {30'h0, txs_q});
	// Register contents follow the latched word address and stay stable through the cycle.
	assign o_csr_rdata = {24'hc0ffee, i_csr.addr};

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fill_q <= 5'h00;
		end else if (o_rxd_valid && i_rxd_ready) begin
			fill_q <= fill_q + 5'h01;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rxs_q <= 2'h0;
			txs_q <= 2'h0;
		end else begin
			if (i_rxs_pop && o_rxs_valid) rxs_q <= rxs_q + 2'h1;
			if (i_txs_pop && o_txs_valid) txs_q <= txs_q + 2'h1;
		end
	end
endmodule // hbr_far_model
`default_nettype wire

// [testbench/hbr_read_port_tb.sv]
// Self-checking bench for the host bus read port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module hbr_read_port_tb
	import hbr_pkg::*;
;
	logic              i_clk, i_rst, fill_en;
	hbr_bus_s          bus;
	hbr_csr_s          csr;
	logic [DATA_W-1:0] o_data, rxd_data, rxs_data, txs_data, csr_rdata;
	logic              oe, rxd_valid, rxd_ready, rxs_valid, rxs_pop, txs_valid, txs_pop;
	int                num_errors = 0, checks = 0, n_rxs = 0, n_txs = 0, n_csr = 0;

	hbr_read_port DUT (.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .o_data(o_data), .o_data_oe(oe),
		.i_rxd_valid(rxd_valid), .i_rxd_data(rxd_data), .o_rxd_ready(rxd_ready),
		.i_rxs_valid(rxs_valid), .i_rxs_data(rxs_data), .o_rxs_pop(rxs_pop),
		.i_txs_valid(txs_valid), .i_txs_data(txs_data), .o_txs_pop(txs_pop),
		.o_csr(csr), .i_csr_rdata(csr_rdata));
	hbr_far_model u_far (.i_clk(i_clk), .i_rst(i_rst), .i_fill_en(fill_en), .i_rxd_ready(rxd_ready),
		.i_rxs_pop(rxs_pop), .i_txs_pop(txs_pop), .i_csr(csr), .o_rxd_valid(rxd_valid),
		.o_rxd_data(rxd_data), .o_rxs_valid(rxs_valid), .o_rxs_data(rxs_data),
		.o_txs_valid(txs_valid), .o_txs_data(txs_data), .o_csr_rdata(csr_rdata));

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		if (!i_rst) begin
			n_rxs += int'(rxs_pop);
			n_txs += int'(txs_pop);
			n_csr += int'(csr.rd);
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic report_and_stop;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// Both strobes go low together; the word has landed four edges later.
	task automatic start(input logic [ADDR_W-1:0] a, input logic es);
		@(posedge i_clk);
		bus.addr <= a;
		bus.end_sel <= es;
		bus.chip_select_n <= 1'b0;
		bus.read_strobe_n <= 1'b0;
		tick(4);
		#1;
	endtask

	// Releasing just one strobe must end the cycle as well as releasing both.
	task automatic stop(input bit strobe_only);
		@(posedge i_clk);
		bus.read_strobe_n <= 1'b1;
		if (!strobe_only) bus.chip_select_n <= 1'b1;
		tick(4);
		#1;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic es, input logic [DATA_W-1:0] exp, input bit so);
		start(a, es);
		`CHK(o_data, exp)
		`CHK(oe, 1'b1)
		stop(so);
		`CHK(oe, 1'b0)
	endtask

	task automatic tog;
		@(posedge i_clk);
		bus.addr[0] <= ~bus.addr[0];
		tick(3);
		#1;
	endtask

	task automatic t_reset;
		`CHK(oe, 1'b0)
		`CHK(o_data, ZERO_WORD)
		`CHK(rxd_ready, 1'b1)
		$display("test reset done");
	endtask

	task automatic t_test_reg;
		rd(TEST_OFS, 1'b0, TEST_VALUE, 1'b1);
		rd(TEST_OFS, 1'b0, TEST_VALUE, 1'b0);
		rd(TEST_OFS, 1'b1, {TEST_VALUE[7:0], TEST_VALUE[15:8], TEST_VALUE[23:16], TEST_VALUE[31:24]}, 1'b0);
		`CHK(n_rxs + n_txs + n_csr, 0)
		$display("test byte-order register done");
	endtask

	task automatic t_status;
		rd(RXS_OFS, 1'b0, 32'h5a00_0000, 1'b0);
		rd(RXS_OFS, 1'b0, 32'h5a00_0001, 1'b1);
		rd(RXS_OFS, 1'b0, ZERO_WORD, 1'b0);
		`CHK(n_rxs, 2)
		rd(TXS_OFS, 1'b0, 32'h3c00_0000, 1'b0);
		rd(TXS_OFS, 1'b0, 32'h3c00_0001, 1'b0);
		rd(TXS_OFS, 1'b0, ZERO_WORD, 1'b1);
		`CHK(n_txs, 2)
		$display("test status queues done");
	endtask

	task automatic t_csr;
		tick(RAR_FIFO_INFO_CYC);
		rd(8'h20, 1'b0, 32'hc0ff_ee20, 1'b0);
		`CHK(n_csr, 1)
		`CHK(csr.addr, 8'h20)
		tick(RAR_DROP_CYC);
		rd(8'h20, 1'b0, 32'hc0ff_ee20, 1'b1);
		rd(TEST_OFS, 1'b0, TEST_VALUE, 1'b0);
		tick(RAW_WAIT_CYC);
		// An address toggle during a register read must neither refresh the word nor add a read pulse.
		start(8'h21, 1'b0);
		`CHK(o_data, 32'hc0ff_ee21)
		tog();
		`CHK(o_data, 32'hc0ff_ee21)
		stop(1'b0);
		`CHK(n_csr, 3)
		$display("test register read done");
	endtask

	task automatic t_burst;
		@(posedge i_clk);
		fill_en <= 1'b1;
		tick(24);
		#1;
		`CHK(rxd_ready, 1'b0)
		start(8'h00, 1'b0);
		`CHK(o_data, 32'hd000_0000)
		for (int k = 1; k < 8; k++) begin
			tog();
			`CHK(o_data, 32'hd000_0000 | k)
		end
		tog();
		`CHK(o_data, 32'hd000_0007)
		stop(1'b0);
		`CHK(rxd_ready, 1'b1)
		for (int k = 8; k < 16; k++) rd(RXD_LAST_OFS, 1'b0, 32'hd000_0000 | k, k[0]);
		rd(8'h00, 1'b0, ZERO_WORD, 1'b0);
		$display("test burst and buffer done");
	endtask

	initial begin
		bus = '{chip_select_n: 1'b1, read_strobe_n: 1'b1, end_sel: 1'b0, addr: 8'h00};
		fill_en = 1'b0;
		i_rst = 1'b1;
		tick(20);
		i_rst <= 1'b0;
		tick(1);
		#1;
		t_reset();
		t_test_reg();
		t_status();
		t_csr();
		t_burst();
		report_and_stop();
	end

	// The tests need well under a thousand cycles.
	initial begin
		#(5000 * 4);
		num_errors++;
		report_and_stop();
	end
endmodule // hbr_read_port_tb
`default_nettype wire
